// ---- include/form_field_key_editor_cfg.svh ----
`ifndef FORM_FIELD_KEY_EDITOR_CFG_SVH
`define FORM_FIELD_KEY_EDITOR_CFG_SVH
`define FKE_BUF_LEN 64
`define FKE_FIELDS 8
`define FKE_LAST_FIELD 3'h7
`define FKE_MSG_BASE 6'h38
`define FKE_MSG_LAST 6'h07
`define FKE_REG_CTRL 12'h000
`define FKE_REG_STATUS 12'h004
`define FKE_REG_ERRSEL 12'h008
`define FKE_FLD_REGION 6'h01
`define FKE_BUF_REGION 4'h1
`define FKE_CTRL_RESET 4'h0
`define FKE_ERR_VALIDATE 4'h1
`define FKE_F_FIRST 5:0
`define FKE_F_LAST 13:8
`define FKE_F_RIGHT 16
`define FKE_F_MENU 17
`define FKE_F_HOME 18
`define FKE_F_MUST 19
`define FKE_F_SEL 20
`define FKE_F_VALID 21
`define FKE_F_CLEAR 31:24
`define FKE_PAD_POINT 4'ha
`define FKE_CHR_POINT 8'h2e
`define FKE_CHR_ZERO 8'h30
`define FKE_CHR_SPACE 8'h20
`endif

// ---- include/form_field_key_editor_pkg.sv ----
package form_field_key_editor_pkg;
  typedef logic [7:0] char_t;
  typedef logic [5:0] pos_t;
  typedef logic [2:0] fidx_t;
  typedef enum logic [3:0] {
    key_char, key_home, key_erase, key_next, key_wipe, key_clear,
    key_remove, key_pick, key_insert, key_ack, key_pad
  } key_code_t;
  typedef struct packed {
    logic valid;
    key_code_t code;
    logic shift;
    char_t ch;
  } key_event_t;
  typedef struct packed {
    logic valid;
    logic [3:0] num;
  } programmable_function_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic right;
    logic menu;
    logic home;
    logic must_fill;
    logic selected;
    char_t clear;
    pos_t first;
    pos_t last;
  } field_t;
  typedef enum logic [2:0] {
    st_idle, st_up, st_dn, st_fill, st_chk, st_msg
  } edit_state_t;
endpackage

// ---- design/form_field_key_editor.sv ----
`timescale 1ns/1ps
`include "form_field_key_editor_cfg.svh"
// Functional notes
// - unshifted home with form fields enabled goes to first form home field start
// - shifted home with menu fields enabled goes to first menu home field start
// - erase in left field past start: step cursor back, erase there
// - erase at field start: cursor stays, character under it erased
// - erase collapses leftward in left fields, rightward in right fields
// - vacated positions take the field's own clear character
// - advance key in last field blanks cursor to end, no move
// - advance key elsewhere blanks cursor to end, then next field start
// - advance key always validates the field being left
// - wipe key clears whole current field, cursor to its start
// - clear in display area deselects menus, cursor to first menu field
// - clear in form area clears form fields, cursor to first form field
// - remove key deletes under cursor, cursor stays, text collapses
// - pick key only in menu mode, display area; shift deselects
// - insert key unshifted enables insert mode, shifted disables it
// - insert in left field: shift at-or-right chars right, store
// - insert in right field: shift at-or-left chars left, store
// - in insert mode a full field drops typed characters and rings bell
// - error writes bottom-line message, bell, error lamp, error mode
// - in error mode keys only ring bell; acknowledge key ends it
// - error from failed validation or host error message request
// - host mode makes keypad give function codes with no shift
module form_field_key_editor
  import form_field_key_editor_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire reg_req_t bus,
  output logic [31:0] rdata,
  input wire key_event_t key,
  output logic key_ready,
  output programmable_function_t programmable_function,
  output logic bell,
  output logic error_led,
  output logic insert_led,
  output logic display_area_led,
  output pos_t cursor
);
  // key events come from same-clock scan logic, so no synchroniser
  char_t buffer [`FKE_BUF_LEN];
  field_t fld [`FKE_FIELDS];
  edit_state_t state, next_state;
  pos_t ptr, stop;
  char_t fin;
  fidx_t cur, work;
  logic fill_all, adv, chk_bad, insert_mode, error_mode, msg_pend;
  logic form_en, menu_en, menu_mode, keypad_func;
  logic [3:0] err_code;

  function automatic logic [3:0] first_field(input logic want_menu,
                                             input logic need_home);
    logic [3:0] r;
    r = 4'h8;
    for (int i = `FKE_FIELDS - 1; i >= 0; i--) begin
      if (fld[i].valid && fld[i].menu == want_menu && (fld[i].home || !need_home)) begin
        r = {1'b0, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic char_t msg_char(input logic [3:0] code, input pos_t i);
    char_t c;
    c = `FKE_CHR_SPACE;
    unique case (i)
      6'h00: c = 8'h45;
      6'h01: c = 8'h52;
      6'h02: c = 8'h52;
      6'h03: c = 8'h4f;
      6'h04: c = 8'h52;
      6'h07: c = `FKE_CHR_ZERO + {4'h0, code};
      default: c = `FKE_CHR_SPACE;
    endcase
    return c;
  endfunction

  function automatic logic [1:0] region(input logic [11:0] a);
    logic [1:0] r;
    r = 2'h0;
    if (a[11:6] == `FKE_FLD_REGION) begin
      r = 2'h1;
    end
    if (a[11:8] == `FKE_BUF_REGION) begin
      r = 2'h2;
    end
    return r;
  endfunction

  // decode
  field_t cf;
  field_t wf;
  field_t nf;
  assign cf = fld[cur];
  assign wf = fld[work];
  assign nf = fld[fidx_t'(cur + 3'h1)];
  wire logic take = key.valid && key_ready;
  wire logic key_go = take && !error_mode;
  wire logic at_start = cursor == cf.first;
  wire logic at_last_pos = cursor == cf.last;
  wire logic last_field = (cur == `FKE_LAST_FIELD) || !nf.valid;
  wire logic field_full = cf.right ? (buffer[cf.first] != cf.clear)
                                   : (buffer[cf.last] != cf.clear);
  wire logic pad_func_key = key.code == key_pad && (keypad_func || key.shift);
  wire logic is_type = key.code == key_char || (key.code == key_pad && !pad_func_key);
  wire char_t pad_char = (key.ch[3:0] == `FKE_PAD_POINT) ? `FKE_CHR_POINT
                       : `FKE_CHR_ZERO + {4'h0, key.ch[3:0]};
  wire char_t type_ch = (key.code == key_pad) ? pad_char : key.ch;
  wire logic type_drop = key_go && is_type && insert_mode && field_full;
  wire logic type_ins = key_go && is_type && insert_mode && !field_full;
  wire logic type_over = key_go && is_type && !insert_mode;
  // procedural so a field table write re-runs the search
  logic [3:0] home_f, menu_f, form_f;
  always_comb begin
    home_f = first_field(key.shift, 1'b1);
    menu_f = first_field(1'b1, 1'b0);
    form_f = first_field(1'b0, 1'b0);
  end
  wire logic home_ok = (key.shift ? menu_en : form_en) && !home_f[3];
  wire pos_t erase_pos = (!cf.right && !at_start) ? pos_t'(cursor - 6'h01) : cursor;
  wire logic fill_skip = fill_all && !(wf.valid && !wf.menu);
  wire logic ptr_end = ptr == stop;
  wire logic chk_hit = wf.must_fill && buffer[ptr] == wf.clear;
  wire logic chk_fail = ptr_end && (chk_bad || chk_hit);
  wire logic host_err = bus.wr && bus.addr == `FKE_REG_ERRSEL && bus.wdata[3:0] != 4'h0;
  wire logic enter_err = (state == st_chk && chk_fail) || host_err;
  wire logic [1:0] bus_region = region(bus.addr);

  // buffer write port: engine first, bus when engine is quiet
  logic buf_we;
  pos_t buf_wa;
  char_t buf_wd;
  always_comb begin
    buf_we = 1'b0;
    buf_wa = ptr;
    buf_wd = wf.clear;
    unique case (state)
      st_up: begin
        buf_we = 1'b1;
        buf_wd = (ptr != stop) ? buffer[pos_t'(ptr + 6'h01)] : fin;
      end
      st_dn: begin
        buf_we = 1'b1;
        buf_wd = (ptr != stop) ? buffer[pos_t'(ptr - 6'h01)] : fin;
      end
      st_fill: begin
        buf_we = !fill_skip;
      end
      st_chk: begin
        buf_we = 1'b0;
      end
      st_msg: begin
        buf_we = 1'b1;
        buf_wa = pos_t'(`FKE_MSG_BASE + ptr);
        buf_wd = msg_char(err_code, ptr);
      end
      st_idle: begin
        buf_we = type_over;
        buf_wa = cursor;
        buf_wd = type_ch;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (buf_we) begin
      buffer[buf_wa] <= buf_wd;
    end else if (bus.wr && bus_region == 2'h2) begin
      buffer[bus.addr[7:2]] <= bus.wdata[7:0];
    end
  end

  // sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle: begin
        if (msg_pend) begin
          next_state = st_msg;
        end else if (key_go) begin
          unique case (key.code)
            key_erase, key_remove: next_state = cf.right ? st_dn : st_up;
            key_next, key_wipe: next_state = st_fill;
            key_clear: next_state = cf.menu ? st_idle : st_fill;
            default: next_state = type_ins ? (cf.right ? st_up : st_dn) : st_idle;
          endcase
        end
      end
      st_up, st_dn: begin
        if (ptr_end) begin
          next_state = st_idle;
        end
      end
      st_fill: begin
        if (fill_all) begin
          if ((ptr_end || fill_skip) && work == `FKE_LAST_FIELD) begin
            next_state = st_idle;
          end
        end else if (ptr_end) begin
          next_state = adv ? st_chk : st_idle;
        end
      end
      st_chk: begin
        if (ptr_end) begin
          next_state = st_idle;
        end
      end
      st_msg: begin
        if (ptr == `FKE_MSG_LAST) begin
          next_state = st_idle;
        end
      end
    endcase
  end

  // ready only while idle with nothing pending; edits never overlap
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= st_idle;
      key_ready <= 1'b0;
    end else begin
      state <= next_state;
      key_ready <= next_state == st_idle && !msg_pend && !enter_err;
    end
  end

  // datapath
  always_ff @(posedge clock) begin
    if (reset) begin
      ptr <= 6'h00;
      stop <= 6'h00;
      fin <= 8'h00;
      cur <= 3'h0;
      work <= 3'h0;
      cursor <= 6'h00;
      fill_all <= 1'b0;
      adv <= 1'b0;
      chk_bad <= 1'b0;
      insert_mode <= 1'b0;
    end else begin
      unique case (state)
        st_idle: begin
          work <= cur;
          if (msg_pend) begin
            ptr <= 6'h00;
          end else if (key_go) begin
            unique case (key.code)
              key_home: begin
                if (home_ok) begin
                  cur <= home_f[2:0];
                  cursor <= fld[home_f[2:0]].first;
                end
              end
              key_erase, key_remove: begin
                ptr <= (key.code == key_erase) ? erase_pos : cursor;
                cursor <= (key.code == key_erase) ? erase_pos : cursor;
                stop <= cf.right ? cf.first : cf.last;
                fin <= cf.clear;
              end
              key_next: begin
                ptr <= cursor;
                stop <= cf.last;
                fill_all <= 1'b0;
                adv <= 1'b1;
              end
              key_wipe: begin
                ptr <= cf.first;
                stop <= cf.last;
                cursor <= cf.first;
                fill_all <= 1'b0;
                adv <= 1'b0;
              end
              key_clear: begin
                if (cf.menu) begin
                  if (!menu_f[3]) begin
                    cur <= menu_f[2:0];
                    cursor <= fld[menu_f[2:0]].first;
                  end
                end else begin
                  work <= 3'h0;
                  ptr <= fld[0].first;
                  stop <= fld[0].last;
                  fill_all <= 1'b1;
                  adv <= 1'b0;
                  if (!form_f[3]) begin
                    cur <= form_f[2:0];
                    cursor <= fld[form_f[2:0]].first;
                  end
                end
              end
              key_insert: begin
                insert_mode <= !key.shift;
              end
              default: begin
                if (type_ins) begin
                  ptr <= cf.right ? cf.first : cf.last;
                  stop <= cursor;
                  fin <= type_ch;
                end else if (type_over && !cf.right && !at_last_pos) begin
                  cursor <= pos_t'(cursor + 6'h01);
                end
              end
            endcase
          end
        end
        st_up: begin
          ptr <= pos_t'(ptr + 6'h01);
        end
        st_dn: begin
          ptr <= pos_t'(ptr - 6'h01);
        end
        st_fill: begin
          if (fill_all && (ptr_end || fill_skip)) begin
            // one field per pass; skipped menu fields cost a cycle each
            work <= fidx_t'(work + 3'h1);
            ptr <= fld[fidx_t'(work + 3'h1)].first;
            stop <= fld[fidx_t'(work + 3'h1)].last;
          end else if (ptr_end) begin
            ptr <= cf.first;
            stop <= cf.last;
            chk_bad <= 1'b0;
          end else begin
            ptr <= pos_t'(ptr + 6'h01);
          end
        end
        st_chk: begin
          chk_bad <= chk_bad || chk_hit;
          ptr <= pos_t'(ptr + 6'h01);
          if (ptr_end && !chk_fail && !last_field) begin
            cur <= fidx_t'(cur + 3'h1);
            cursor <= nf.first;
          end
        end
        st_msg: begin
          ptr <= pos_t'(ptr + 6'h01);
        end
      endcase
    end
  end

  // field table: engine owns the selection bit when it acts
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < `FKE_FIELDS; i++) begin
        fld[i] <= '0;
      end
    end else if (key_go && key.code == key_clear && cf.menu) begin
      for (int i = 0; i < `FKE_FIELDS; i++) begin
        if (fld[i].menu) begin
          fld[i].selected <= 1'b0;
        end
      end
    end else if (key_go && key.code == key_pick && menu_mode && cf.menu) begin
      fld[cur].selected <= !key.shift;
    end else if (bus.wr && bus_region == 2'h1) begin
      fld[bus.addr[4:2]].valid <= bus.wdata[`FKE_F_VALID];
      fld[bus.addr[4:2]].right <= bus.wdata[`FKE_F_RIGHT];
      fld[bus.addr[4:2]].menu <= bus.wdata[`FKE_F_MENU];
      fld[bus.addr[4:2]].home <= bus.wdata[`FKE_F_HOME];
      fld[bus.addr[4:2]].must_fill <= bus.wdata[`FKE_F_MUST];
      fld[bus.addr[4:2]].selected <= bus.wdata[`FKE_F_SEL];
      fld[bus.addr[4:2]].clear <= bus.wdata[`FKE_F_CLEAR];
      fld[bus.addr[4:2]].first <= bus.wdata[`FKE_F_FIRST];
      fld[bus.addr[4:2]].last <= bus.wdata[`FKE_F_LAST];
    end
  end

  // error mode; a new error in the acknowledge cycle keeps it set
  always_ff @(posedge clock) begin
    if (reset) begin
      error_mode <= 1'b0;
      msg_pend <= 1'b0;
      err_code <= 4'h0;
    end else begin
      if (enter_err) begin
        error_mode <= 1'b1;
        msg_pend <= 1'b1;
        err_code <= host_err ? bus.wdata[3:0] : `FKE_ERR_VALIDATE;
      end else begin
        if (take && error_mode && key.code == key_ack) begin
          error_mode <= 1'b0;
        end
        if (state == st_idle) begin
          msg_pend <= 1'b0;
        end
      end
    end
  end

  // control register and outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      {keypad_func, menu_mode, menu_en, form_en} <= `FKE_CTRL_RESET;
    end else if (bus.wr && bus.addr == `FKE_REG_CTRL) begin
      {keypad_func, menu_mode, menu_en, form_en} <= bus.wdata[3:0];
    end
  end

  wire logic ring = type_drop
                 || (take && error_mode && key.code != key_ack)
                 || enter_err;
  always_ff @(posedge clock) begin
    if (reset) begin
      bell <= 1'b0;
      programmable_function <= '0;
      error_led <= 1'b0;
      insert_led <= 1'b0;
      display_area_led <= 1'b0;
    end else begin
      bell <= ring;
      programmable_function.valid <= key_go && pad_func_key;
      programmable_function.num <= key.ch[3:0];
      error_led <= error_mode || enter_err;
      insert_led <= insert_mode;
      display_area_led <= cf.menu;
    end
  end

  // register reads; unmapped offsets read as zero
  field_t rf;
  assign rf = fld[bus.addr[4:2]];
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    if (bus.addr == `FKE_REG_CTRL) begin
      rd_word[3:0] = {keypad_func, menu_mode, menu_en, form_en};
    end else if (bus.addr == `FKE_REG_STATUS) begin
      rd_word[5:0] = cursor;
      rd_word[10:8] = cur;
      rd_word[12] = insert_mode;
      rd_word[13] = error_mode;
      rd_word[14] = state != st_idle;
      rd_word[19:16] = err_code;
    end else if (bus.addr == `FKE_REG_ERRSEL) begin
      rd_word[3:0] = err_code;
    end else if (bus_region == 2'h1) begin
      rd_word[`FKE_F_VALID] = rf.valid;
      rd_word[`FKE_F_RIGHT] = rf.right;
      rd_word[`FKE_F_MENU] = rf.menu;
      rd_word[`FKE_F_HOME] = rf.home;
      rd_word[`FKE_F_MUST] = rf.must_fill;
      rd_word[`FKE_F_SEL] = rf.selected;
      rd_word[`FKE_F_CLEAR] = rf.clear;
      rd_word[`FKE_F_FIRST] = rf.first;
      rd_word[`FKE_F_LAST] = rf.last;
    end else if (bus_region == 2'h2) begin
      rd_word[7:0] = buffer[bus.addr[7:2]];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= rd_word;
    end
  end
endmodule // form_field_key_editor

// ---- verification/form_field_key_editor_properties.sv ----
`timescale 1ns/1ps
module form_field_key_editor_properties
  import form_field_key_editor_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire reg_req_t bus,
  input wire logic [31:0] rdata,
  input wire key_event_t key,
  input wire logic key_ready,
  input wire programmable_function_t programmable_function,
  input wire logic bell,
  input wire logic error_led,
  input wire logic insert_led,
  input wire logic display_area_led,
  input wire pos_t cursor
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  wire logic take = key.valid && key_ready;
  // host writes excluded: a host error may land in the same cycle
  wire logic calm = take && !error_led && !bus.wr;
  sequence s_busy;
    !key_ready ##[1:200] key_ready;
  endsequence
  sequence s_bell;
    bell || $past(bell);
  endsequence
  AST_ERR_BELL: assert property ($rose(error_led) |-> s_bell or ##1 bell)
    else $error("no bell at error entry");
  AST_ERR_BUSY: assert property ($rose(error_led) |-> ##[0:2] !key_ready)
    else $error("no message drawn at error entry");
  // the lamp trails error mode by one cycle after an acknowledge
  AST_ERR_KEYS: assert property (take && error_led && key.code != key_ack
    && !$past(take && key.code == key_ack) |=> bell && error_led && $stable(cursor))
    else $error("key acted in error mode");
  AST_ACK: assert property (take && error_led && key.code == key_ack && !bus.wr
    |=> (bus.wr && bus.addr == 12'h008) or ##1 !error_led)
    else $error("acknowledge left error mode on");
  AST_INSERT: assert property (calm && key.code == key_insert
    |=> ##1 insert_led == !$past(key.shift, 2))
    else $error("insert mode wrong");
  AST_EDIT: assert property (calm && key.code == key_erase |=> s_busy)
    else $error("erase did not hold keys off");
  AST_BACK: assert property ($fell(key_ready) |-> ##[1:200] key_ready)
    else $error("keys held off too long");
  AST_PROG_FUNC: assert property (calm && key.code == key_pad && key.shift
    && key.ch[3:0] != 4'h7 && key.ch[3:0] <= 4'ha
    |=> programmable_function.valid && programmable_function.num == $past(key.ch[3:0]))
    else $error("shifted keypad gave no function code");
endmodule // form_field_key_editor_properties
bind form_field_key_editor form_field_key_editor_properties u_props (
  .clock(clock), .reset(reset), .bus(bus), .rdata(rdata), .key(key),
  .key_ready(key_ready), .programmable_function(programmable_function), .bell(bell),
  .error_led(error_led), .insert_led(insert_led), .display_area_led(display_area_led),
  .cursor(cursor)
);

// ---- verification/key_source.sv ----
`timescale 1ns/1ps
module key_source
  import form_field_key_editor_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic key_ready,
  output key_event_t key
);
  int gap = 0;
  initial key = '{valid: 1'b0, code: key_char, shift: 1'b0, ch: 8'h00};
  task automatic press(input key_code_t c, input logic s, input char_t ch);
    int n;
    n = 0;
    while (reset) @(posedge clock);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    key <= '{valid: 1'b1, code: c, shift: s, ch: ch};
    do begin
      @(posedge clock);
      n++;
    end while (key_ready !== 1'b1 && n < 500);
    // stale lines inverted so a late sample cannot pass for a match
    key <= '{valid: 1'b0, code: key_code_t'(~c), shift: ~s, ch: ~ch};
  endtask
endmodule // key_source

// ---- verification/form_field_key_editor_tb_top.sv ----
`timescale 1ns/1ps
module form_field_key_editor_tb_top;
  import form_field_key_editor_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  reg_req_t bus = '0;
  logic [31:0] rdata;
  key_event_t key;
  programmable_function_t programmable_function;
  logic key_ready, bell, error_led, insert_led, display_area_led;
  pos_t cursor;
  int err_total = 0;
  int comparisons = 0;
  int bells = 0;
  int func_codes = 0;
  int b;
  logic [3:0] func_num = '0;
  logic [31:0] d;
  char_t r[4];
  char_t e[8];
  char_t c;
  always #5 clock = ~clock;
  form_field_key_editor u_form_field_key_editor (
    .clock(clock), .reset(reset), .bus(bus), .rdata(rdata), .key(key),
    .key_ready(key_ready), .programmable_function(programmable_function), .bell(bell),
    .error_led(error_led), .insert_led(insert_led), .display_area_led(display_area_led),
    .cursor(cursor)
  );
  key_source u_key_source (.clock(clock), .reset(reset), .key_ready(key_ready), .key(key));
  always @(posedge clock) begin
    if (bell === 1'b1) bells <= bells + 1;
    if (programmable_function.valid === 1'b1) begin
      func_codes <= func_codes + 1;
      func_num <= programmable_function.num;
    end
  end
  function automatic logic [31:0] fword(input pos_t f, input pos_t l, input logic [3:0] fl,
                                        input char_t cc);
    return {cc, 2'b00, 1'b1, 1'b0, fl, 2'b00, l, 2'b00, f};
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cur(input pos_t p);
    chk(32'(cursor), 32'(p));
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock);
    bus <= '0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v);
    @(posedge clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge clock);
    bus <= '0;
    @(posedge clock);
    v = rdata;
  endtask
  task automatic chk_buf(input int p, input char_t x);
    logic [31:0] v;
    rd(12'h100 + 12'(4 * p), v);
    chk(v, {24'h0, x});
  endtask
  task automatic chk_text(input int p, input string s);
    for (int i = 0; i < s.len(); i++) chk_buf(p + i, s[i]);
  endtask
  task automatic idle();
    int n;
    n = 0;
    repeat (3) @(posedge clock);
    while (key_ready !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
  endtask
  task automatic kp(input key_code_t k, input logic s = 1'b0, input char_t ch = 8'h00);
    u_key_source.press(k, s, ch);
    idle();
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_of_test();
  end
  initial begin
    void'($urandom(32'h0a4e));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd(12'h000, d);
    chk(d, 32'h0);
    rd(12'h004, d);
    chk(d, 32'h0);
    rd(12'hffc, d);
    chk(d, 32'h0);
    done("reset");
    wr(12'h040, fword(6'h00, 6'h07, 4'b0100, 8'h5f));
    wr(12'h044, fword(6'h08, 6'h0f, 4'b0001, 8'h30));
    wr(12'h048, fword(6'h10, 6'h17, 4'b1000, 8'h20));
    wr(12'h04c, fword(6'h18, 6'h1f, 4'b0110, 8'h2e));
    wr(12'h000, 32'h3);
    kp(key_clear);
    chk_cur(6'h00);
    chk_text(0, "________00000000        ");
    for (int i = 0; i < 4; i++) begin
      r[i] = 8'h41 + 8'($urandom_range(25));
      kp(key_char, 1'b0, r[i]);
    end
    kp(key_erase);
    chk_cur(6'h03);
    chk_text(0, $sformatf("%c%c%c_____", r[0], r[1], r[2]));
    kp(key_home);
    chk_cur(6'h00);
    kp(key_erase);
    chk_cur(6'h00);
    chk_text(0, $sformatf("%c%c______", r[1], r[2]));
    kp(key_remove);
    chk_cur(6'h00);
    chk_text(0, $sformatf("%c_______", r[2]));
    done("erase");
    // slow operator here: holds each key a few cycles before offering
    u_key_source.gap = 2;
    kp(key_insert);
    chk(32'(insert_led), 32'h1);
    e[0] = r[2];
    for (int j = 1; j < 8; j++) e[j] = 8'h5f;
    b = bells;
    for (int i = 0; i < 8; i++) begin
      c = 8'h61 + 8'($urandom_range(25));
      kp(key_home);
      kp(key_char, 1'b0, c);
      if (i < 7) begin
        for (int j = 7; j > 0; j--) e[j] = e[j - 1];
        e[0] = c;
      end
    end
    chk(bells, b + 1);
    for (int j = 0; j < 8; j++) chk_buf(j, e[j]);
    kp(key_insert, 1'b1);
    chk(32'(insert_led), 32'h0);
    u_key_source.gap = 0;
    done("insert");
    kp(key_home);
    kp(key_next);
    chk_cur(6'h08);
    chk(32'(error_led), 32'h0);
    chk_text(0, "________");
    for (int i = 0; i < 7; i++) kp(key_char, 1'b0, 8'h31 + 8'(i));
    // right fields type in place: the cursor stays on the field start
    chk_cur(6'h08);
    chk_text(8, "70000000");
    kp(key_insert);
    b = bells;
    kp(key_char, 1'b0, 8'h4b);
    chk(bells, b + 1);
    chk_text(8, "70000000");
    wr(12'h120, 32'h30);
    wr(12'h124, 32'h4d);
    kp(key_char, 1'b0, 8'h4b);
    chk_text(8, "KM000000");
    kp(key_insert, 1'b1);
    kp(key_wipe);
    chk_cur(6'h08);
    chk_text(8, "00000000");
    done("right field");
    kp(key_next);
    chk_cur(6'h10);
    kp(key_char, 1'b0, 8'h51);
    b = bells;
    kp(key_next);
    chk(32'(error_led), 32'h1);
    chk(bells, b + 1);
    chk(32'(cursor[5:3]), 32'h2);
    rd(12'h004, d);
    chk(32'(d[19:16]), 32'h1);
    chk_text(56, "ER");
    kp(key_char, 1'b0, 8'h59);
    chk(bells, b + 2);
    chk_text(16, "Q       ");
    kp(key_ack);
    chk(32'(error_led), 32'h0);
    wr(12'h008, 32'h5);
    idle();
    chk(32'(error_led), 32'h1);
    rd(12'h004, d);
    chk(32'(d[19:16]), 32'h5);
    kp(key_ack);
    done("errors");
    kp(key_home, 1'b1);
    chk_cur(6'h18);
    chk(32'(display_area_led), 32'h1);
    wr(12'h160, 32'h41);
    kp(key_next);
    chk_cur(6'h18);
    chk_text(24, "........");
    for (int i = 0; i < 5; i++) begin
      if (i == 1) wr(12'h000, 32'h7);
      kp(i == 4 ? key_clear : key_pick, i == 2);
      rd(12'h04c, d);
      chk(32'(d[20]), (i == 1 || i == 3) ? 32'h1 : 32'h0);
    end
    chk_cur(6'h18);
    done("menu");
    wr(12'h000, 32'hf);
    b = func_codes;
    kp(key_pad, 1'b0, 8'h03);
    chk(32'(func_num), 32'h3);
    wr(12'h000, 32'h7);
    kp(key_pad, 1'b0, 8'h05);
    chk(func_codes, b + 1);
    kp(key_pad, 1'b1, 8'h04);
    chk(32'(func_num), 32'h4);
    done("keypad");
    kp(key_clear);
    chk_cur(6'h18);
    kp(key_home);
    chk_cur(6'h00);
    kp(key_next);
    kp(key_clear);
    chk_cur(6'h00);
    chk_text(16, "        ");
    done("form reset");
    end_of_test();
  end
endmodule // form_field_key_editor_tb_top
